//--- design/dshift_sub_pkg.sv
// What this block does
// - Arithmetic right shift upper moves operand B right by the shift amount field plus 32 with bit 63 copied into the top.
// - Arithmetic right shift upper is decoded from major opcode 000000, bits 25..21 zero and function 111111.
// - Arithmetic right shift variable moves operand B right by operand A bits 5..0, copying bit 63 into the top.
// - Arithmetic right shift variable is decoded from major opcode 000000, bits 10..6 zero and function 010111.
// - Logical right shift fixed moves operand B right by the shift amount field (0 to 31) with zeros in the top.
// - Logical right shift fixed is decoded from major opcode 000000, bits 25..21 zero and function 111010.
// - Logical right shift upper moves operand B right by the shift amount field plus 32 with zeros in the top.
// - Logical right shift upper is decoded from major opcode 000000, bits 25..21 zero and function 111110.
// - Logical right shift variable moves operand B right by operand A bits 5..0 with zeros in the top.
// - Logical right shift variable is decoded from major opcode 000000, bits 10..6 zero and function 010110.
// - Checked subtract gives A minus B and on signed overflow suppresses the write and raises the overflow flag.
// - Checked subtract is decoded from opcode 000000, bits 10..6 zero, function 101110, and writes when no overflow.
// - Wrapping subtract always writes the modulo difference A minus B and never raises the overflow flag.
// - Wrapping subtract is decoded from major opcode 000000, bits 10..6 zero and function 101111.
// - A subtract that ignores overflow is plain 64-bit modulo arithmetic that never traps.
package dshift_sub_pkg;
  localparam int         DATA_W      = 64;
  localparam logic [5:0] OPC_SPECIAL = 6'h00;
  localparam logic [4:0] ZERO_FIELD  = 5'h00;
  localparam logic [5:0] FN_ARU      = 6'h3f; // Arith right shift upper
  localparam logic [5:0] FN_ARV      = 6'h17; // Arith right shift variable
  localparam logic [5:0] FN_LRF      = 6'h3a; // Logic right shift fixed
  localparam logic [5:0] FN_LRU      = 6'h3e; // Logic right shift upper
  localparam logic [5:0] FN_LRV      = 6'h16; // Logic right shift variable
  localparam logic [5:0] FN_CSUB     = 6'h2e; // Checked subtract
  localparam logic [5:0] FN_WSUB     = 6'h2f; // Wrapping subtract
  localparam logic [5:0] UPPER_OFS   = 6'h20; // Added for the upper shifts
  localparam logic [63:0] RESULT_RST = 64'h0;

  // Decoded instruction fields from the decode stage
  typedef struct packed {
    logic       valid;
    logic [5:0] opcode;
    logic [4:0] operand_a_select;
    logic [4:0] operand_b_select;
    logic [4:0] dest_select;
    logic [4:0] shift_amount_field;
    logic [5:0] funct;
  } instr_t;

  // Answer handed to write back
  typedef struct packed {
    logic        write_en;
    logic        overflow_exc;
    logic [4:0]  dest_select;
    logic [63:0] result;
  } answer_t;
endpackage : dshift_sub_pkg

//--- design/dword_shift_right_subtract_alu.sv
`timescale 1ns/1ps
module dword_shift_right_subtract_alu
  import dshift_sub_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire instr_t      instr,
  input  wire logic [63:0] operand_a,
  input  wire logic [63:0] operand_b,
  output answer_t          answer
);

  answer_t     ans_reg;
  answer_t     ans_next;
  logic        is_special;
  logic        hi_zero;
  logic        mid_zero;
  logic [5:0]  shamt;
  logic        arith;
  logic        is_shift;
  logic        is_csub;
  logic        is_wsub;
  logic [63:0] diff;
  logic        ovf;
  logic [63:0] shifted;

  // Decode; shifts with a fixed amount need bits 25..21 clear
  always_comb begin
    is_special = instr.valid && (instr.opcode == OPC_SPECIAL);
    hi_zero    = (instr.operand_a_select == ZERO_FIELD);
    mid_zero   = (instr.shift_amount_field == ZERO_FIELD);
    is_shift   = 1'b0;
    arith      = 1'b0;
    shamt      = {1'b0, instr.shift_amount_field};
    is_csub    = 1'b0;
    is_wsub    = 1'b0;
    if (is_special) begin
      case (instr.funct)
        FN_ARU: begin
          is_shift = hi_zero;
          arith    = 1'b1;
          shamt    = UPPER_OFS | {1'b0, instr.shift_amount_field};
        end
        FN_ARV: begin
          is_shift = mid_zero;
          arith    = 1'b1;
          shamt    = operand_a[5:0];
        end
        FN_LRF: begin
          is_shift = hi_zero;
        end
        FN_LRU: begin
          is_shift = hi_zero;
          shamt    = UPPER_OFS | {1'b0, instr.shift_amount_field};
        end
        FN_LRV: begin
          is_shift = mid_zero;
          shamt    = operand_a[5:0];
        end
        FN_CSUB: is_csub = mid_zero;
        FN_WSUB: is_wsub = mid_zero;
        default: is_shift = 1'b0;
      endcase
    end
  end

  // Shared barrel shifter; sign fill only for the arithmetic forms
  always_comb begin
    if (arith) begin
      shifted = $signed(operand_b) >>> shamt;
    end else begin
      shifted = operand_b >> shamt;
    end
  end

  // One subtractor serves both forms; overflow when signs differ
  // and the result sign differs from operand A
  always_comb begin
    diff = operand_a - operand_b;
    ovf  = (operand_a[63] != operand_b[63]) && (diff[63] != operand_a[63]);
  end

  // Next answer; unknown functions write nothing
  always_comb begin
    ans_next              = '0;
    ans_next.dest_select  = instr.dest_select;
    if (is_shift) begin
      ans_next.write_en = 1'b1;
      ans_next.result   = shifted;
    end else if (is_csub) begin
      ans_next.write_en     = !ovf;
      ans_next.overflow_exc = ovf;
      ans_next.result       = diff;
    end else if (is_wsub) begin
      ans_next.write_en = 1'b1;
      ans_next.result   = diff;
    end
  end

  // Single execute stage register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ans_reg <= '0;
    end else begin
      ans_reg <= ans_next;
    end
  end

  assign answer = ans_reg;

  // Checks
  // Decode qualifier folded into the sequence, so no named sequence is
  // ever an operand of a logical and
  sequence s_req(logic [5:0] fn, logic ok);
    instr.valid && instr.opcode == OPC_SPECIAL && instr.funct == fn && ok;
  endsequence

  a_aru_result: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, hi_zero) |=> answer.result ==
      64'($signed($past(operand_b)) >>>
      (7'd32 + 7'($past(instr.shift_amount_field)))))
    else $error("upper arithmetic shift wrong");
  a_aru_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, !hi_zero) |=> !answer.write_en)
    else $error("upper arithmetic shift with nonzero field written");
  a_arv_result: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARV, mid_zero) |=> answer.write_en && answer.result ==
      64'($signed($past(operand_b)) >>> $past(operand_a[5:0])))
    else $error("variable arithmetic shift wrong");
  a_arv_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARV, !mid_zero) |=> !answer.write_en)
    else $error("variable arithmetic shift bad field written");
  a_lrf_result: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRF, hi_zero) |=> answer.write_en && answer.result ==
      ($past(operand_b) >> $past(instr.shift_amount_field)))
    else $error("fixed logical shift wrong");
  a_lrf_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRF, !hi_zero) |=> !answer.write_en)
    else $error("fixed logical shift bad field written");
  a_lru_result: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRU, hi_zero) |=> answer.result[63:32] == 32'h0 &&
      answer.result[31:0] == 32'($past(operand_b[63:32]) >>
      $past(instr.shift_amount_field)))
    else $error("upper logical shift wrong");
  a_lru_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRU, !hi_zero) |=> !answer.write_en)
    else $error("upper logical shift bad field written");
  a_lrv_result: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRV, mid_zero) |=> answer.result ==
      ($past(operand_b) >> $past(operand_a[5:0])))
    else $error("variable logical shift wrong");
  a_lrv_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRV, !mid_zero) |=> !answer.write_en)
    else $error("variable logical shift bad field written");
  a_csub_trap: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_CSUB, mid_zero && ovf) |=>
      answer.overflow_exc && !answer.write_en)
    else $error("checked subtract overflow not trapped");
  a_csub_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_CSUB, mid_zero && !ovf) |=> answer.write_en &&
      !answer.overflow_exc &&
      answer.result == $past(operand_a) - $past(operand_b))
    else $error("checked subtract result wrong");
  a_wsub_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_WSUB, mid_zero) |=> answer.write_en &&
      !answer.overflow_exc &&
      answer.result == $past(operand_a) - $past(operand_b))
    else $error("wrapping subtract wrong");
  a_wsub_decode: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_WSUB, !mid_zero) |=> !answer.write_en)
    else $error("wrapping subtract bad field written");
  a_exc_source: assert property (@(posedge clk_sys) disable iff (rst)
    answer.overflow_exc |-> $past(is_csub))
    else $error("overflow raised by other than checked subtract");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    !instr.valid |=> !answer.write_en && !answer.overflow_exc)
    else $error("answer without request");

  // Second overflow method through a sign-extended difference; the trap
  // checks below lean on it, so a broken ovf term cannot hide itself
  logic [64:0] wide_diff;
  logic        wide_ovf;
  always_comb begin
    wide_diff = {operand_a[63], operand_a} - {operand_b[63], operand_b};
    wide_ovf  = wide_diff[64] != wide_diff[63];
  end

  // Subtract forms: results against the second method, bad field and trap checks
  a_csub_wtrap: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_CSUB, mid_zero && wide_ovf) |=> answer.overflow_exc &&
      !answer.write_en && answer.result == $past(wide_diff[63:0]))
    else $error("checked subtract trap wrong");

  a_csub_wok: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_CSUB, mid_zero && !wide_ovf) |=> answer.write_en &&
      !answer.overflow_exc && answer.result == $past(wide_diff[63:0]))
    else $error("checked subtract without overflow wrong");

  a_csub_bad: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_CSUB, !mid_zero) |=> !answer.write_en && !answer.overflow_exc)
    else $error("checked subtract bad field acted on");

  a_wsub_clean: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_WSUB, 1'b1) |=> !answer.overflow_exc)
    else $error("wrapping subtract raised overflow");

  a_wsub_wrap: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_WSUB, mid_zero && wide_ovf) |=> answer.write_en &&
      answer.result == $past(wide_diff[63:0]))
    else $error("wrapping subtract did not wrap");

  a_trap_mute: assert property (@(posedge clk_sys) disable iff (rst)
    answer.overflow_exc |-> !answer.write_en)
    else $error("trap with write enable");

  // Shift forms: write enable, sign fill and end points of the count
  a_aru_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, hi_zero) |=> answer.write_en)
    else $error("upper arithmetic shift not written");

  a_aru_fill: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, hi_zero) |=>
      answer.result[63:32] == {32{$past(operand_b[63])}})
    else $error("upper arithmetic shift top not sign");

  a_aru_min: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, hi_zero && instr.shift_amount_field == ZERO_FIELD) |=>
      answer.result == {{32{$past(operand_b[63])}}, $past(operand_b[63:32])})
    else $error("upper arithmetic shift by 32 wrong");

  a_aru_max: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARU, hi_zero && instr.shift_amount_field == 5'h1f) |=>
      answer.result == {64{$past(operand_b[63])}})
    else $error("upper arithmetic shift by 63 wrong");

  a_arv_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARV, mid_zero && operand_a[5:0] == 6'h00) |=>
      answer.result == $past(operand_b))
    else $error("variable arithmetic shift by 0 wrong");

  a_arv_fill: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_ARV, mid_zero && operand_a[5:0] == 6'h3f) |=>
      answer.result == {64{$past(operand_b[63])}})
    else $error("variable arithmetic shift by 63 wrong");

  a_lrf_keep: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRF, hi_zero && instr.shift_amount_field == ZERO_FIELD) |=>
      answer.result == $past(operand_b))
    else $error("fixed logical shift by 0 wrong");

  a_lrf_top: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRF, hi_zero && instr.shift_amount_field != ZERO_FIELD) |=>
      !answer.result[63])
    else $error("fixed logical shift top bit not zero");

  a_lrf_max: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRF, hi_zero && instr.shift_amount_field == 5'h1f) |=>
      answer.result == {31'h0, $past(operand_b[63:31])})
    else $error("fixed logical shift by 31 wrong");

  a_lru_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRU, hi_zero) |=> answer.write_en)
    else $error("upper logical shift not written");

  a_lru_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRU, hi_zero && instr.shift_amount_field == ZERO_FIELD) |=>
      answer.result == {32'h0, $past(operand_b[63:32])})
    else $error("upper logical shift by 32 wrong");

  a_lru_max: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRU, hi_zero && instr.shift_amount_field == 5'h1f) |=>
      answer.result == {63'h0, $past(operand_b[63])})
    else $error("upper logical shift by 63 wrong");

  a_lrv_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRV, mid_zero) |=> answer.write_en)
    else $error("variable logical shift not written");

  a_lrv_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRV, mid_zero && operand_a[5:0] == 6'h00) |=>
      answer.result == $past(operand_b))
    else $error("variable logical shift by 0 wrong");

  a_lrv_top: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(FN_LRV, mid_zero && operand_a[5:0] != 6'h00) |=>
      !answer.result[63])
    else $error("variable logical shift top bit not zero");

  // Decode and stage behaviour common to every request
  a_bad_opcode: assert property (@(posedge clk_sys) disable iff (rst)
    instr.opcode != OPC_SPECIAL |=> !answer.write_en && !answer.overflow_exc)
    else $error("request outside the special opcode acted on");

  a_bad_funct: assert property (@(posedge clk_sys) disable iff (rst)
    s_req(6'h3b, 1'b1) |=> !answer.write_en && !answer.overflow_exc)
    else $error("excluded function code acted on");

  a_dest_copy: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> answer.dest_select == $past(instr.dest_select))
    else $error("destination not carried one cycle");

  a_idle_zero: assert property (@(posedge clk_sys) disable iff (rst)
    !instr.valid |=> answer.result == 64'h0)
    else $error("result without request");

  // Reset is checked on its own, so this one has no disable clause
  a_reset_clear: assert property (@(posedge clk_sys)
    rst |=> answer == '0)
    else $error("answer not cleared by reset");

endmodule : dword_shift_right_subtract_alu

//--- tb/reg_file_model.sv
`timescale 1ns/1ps
// Register file feeding the block: two read ports and one load port
module reg_file_model
  import dshift_sub_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        load_en,
  input  wire logic [4:0]  load_sel,
  input  wire logic [63:0] load_data,
  input  wire instr_t      instr,
  output logic [63:0]      operand_a,
  output logic [63:0]      operand_b
);
  logic [63:0] regs_reg [32];

  // No write back, so the bench shadow copy stays exact
  always_ff @(posedge clk_sys) begin
    if (load_en) begin
      regs_reg[load_sel] <= load_data;
    end
  end

  // Reads are combinational, as in the decode stage
  assign operand_a = regs_reg[instr.operand_a_select];
  assign operand_b = regs_reg[instr.operand_b_select];
endmodule : reg_file_model

//--- tb/dword_shift_right_subtract_alu_test.sv
`timescale 1ns/1ps
module dword_shift_right_subtract_alu_test;
  import dshift_sub_pkg::*;
  logic        clk_sys;
  logic        rst = 1'b1;
  instr_t      instr = '0;
  logic [63:0] operand_a;
  logic [63:0] operand_b;
  answer_t     answer;
  answer_t     exp_a;
  logic        load_en = 1'b0;
  logic [4:0]  load_sel = 5'h00;
  logic [63:0] load_data = 64'h0;
  logic [63:0] shadow [32];
  logic [63:0] r;
  logic [63:0] seed = 64'h0000_0000_0000_8523;
  answer_t     notes [$];
  int          fail_count;
  int          checked;
  // Last entry is an excluded code that must be refused
  logic [5:0]  fn_tab [8] = '{FN_ARU, FN_ARV, FN_LRF, FN_LRU, FN_LRV,
                              FN_CSUB, FN_WSUB, 6'h3b};

  dword_shift_right_subtract_alu i_dut (.clk_sys(clk_sys), .rst(rst),
    .instr(instr), .operand_a(operand_a), .operand_b(operand_b),
    .answer(answer));
  reg_file_model i_regs (.clk_sys(clk_sys), .load_en(load_en),
    .load_sel(load_sel), .load_data(load_data), .instr(instr),
    .operand_a(operand_a), .operand_b(operand_b));

  // 50 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function logic [63:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 7;
    seed ^= seed << 17;
    return seed;
  endfunction : rnd

  // Expected answer from the shadow registers
  function automatic answer_t predict(instr_t q);
    answer_t            e;
    logic [63:0]        a;
    logic [63:0]        b;
    logic [63:0]        d;
    logic signed [63:0] sb;
    logic [5:0]         up;
    logic               ok;
    a = shadow[q.operand_a_select];
    b = shadow[q.operand_b_select];
    sb = b;
    d = a - b;
    up = {1'b1, q.shift_amount_field};
    e = '0;
    e.dest_select = q.dest_select;
    // Fixed and upper shift codes all have 111 in the top bits
    ok = q.valid && q.opcode == OPC_SPECIAL && ((q.funct[5:3] == 3'h7) ?
         q.operand_a_select == ZERO_FIELD : q.shift_amount_field == ZERO_FIELD);
    case (q.funct)
      FN_ARU:  e.result = sb >>> up;
      FN_ARV:  e.result = sb >>> a[5:0];
      FN_LRF:  e.result = b >> q.shift_amount_field;
      FN_LRU:  e.result = b >> up;
      FN_LRV:  e.result = b >> a[5:0];
      FN_CSUB: e.result = d;
      FN_WSUB: e.result = d;
      default: ok = 1'b0;
    endcase
    e.overflow_exc = ok && q.funct == FN_CSUB && a[63] != b[63] &&
                     d[63] != a[63];
    e.write_en = ok && !e.overflow_exc;
    if (!ok) e.result = '0;
    return e;
  endfunction : predict

  task automatic check(input logic [70:0] seen, input logic [70:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // A note taken at this edge is answered right after it
  always @(posedge clk_sys) begin
    if (notes.size() > 0) begin
      exp_a = notes.pop_front();
      #2;
      check(answer, exp_a);
    end
  end

  // Run is about 450 cycles; this is over twice that
  initial begin
    repeat (1000) @(posedge clk_sys);
    fail_count++;
    close_out();
  end

  // Preload, back-to-back random requests, then a reset and one idle request
  initial begin
    repeat (12) @(posedge clk_sys);
    #1;
    check(answer, '0);
    rst = 1'b0;
    load_en = 1'b1;
    for (int i = 0; i < 32; i++) begin
      shadow[i] = (i == 1) ? 64'h8000_0000_0000_0000 : (i == 2) ? 64'h1 :
                  (i == 3) ? 64'h7fff_ffff_ffff_ffff : rnd();
      load_sel = 5'(i);
      load_data = shadow[i];
      @(posedge clk_sys);
      #1;
    end
    load_en = 1'b0;
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      instr.valid = r[0] | r[1];
      instr.opcode = (r[4:2] == 3'h0) ? r[10:5] : OPC_SPECIAL;
      instr.funct = fn_tab[r[13:11]];
      instr.operand_a_select = r[14] ? 5'h00 : r[21:17];
      instr.shift_amount_field = r[15] ? 5'h00 : r[26:22];
      instr.operand_b_select = r[31:27];
      instr.dest_select = r[36:32];
      notes.push_back(predict(instr));
      @(posedge clk_sys);
      #1;
    end
    rst = 1'b1;
    notes.push_back('0);
    @(posedge clk_sys);
    #1;
    rst = 1'b0;
    instr.valid = 1'b0;
    notes.push_back(predict(instr));
    @(posedge clk_sys);
    #3;
    close_out();
  end
endmodule : dword_shift_right_subtract_alu_test
